/* File: rtl/adcr_regs.sv */
// Control register bank and start-up sequencer of the converter's digital side.
// Assumes the conversion word and overrange flag come from the filter datapath,
// and that sync_n is already synchronous to clk_sys.
//
// The Avalon-MM register port was chosen for this implementation.

// Contract
// - Data flagged invalid until filter settles, then settled flag set.
// - Default gain and threshold used until written; both readable and writable.
// - Register write is an address followed by a 16-bit data word.
// - Control at 0x0001, reset 0x0000, documented fields only, others zero.
// - Threshold select makes the next read return the threshold register.
// - Gain select makes the next read return the gain register.
// - Control drives reference buffer, amplifier and power-down.
// - Status select makes the next read return the status register.
// - Bits 14 to 11 and 9 clear themselves after taking effect.
// - Power-down bit stops the converter without reset; zero resumes.
module adcr_regs #(
  parameter int SETTLE_CYC = adcr_pkg::SETTLE_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [adcr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic sync_n,
  input wire logic [23:0] conv_data,
  input wire logic conv_valid,
  input wire logic overrange,
  input wire logic [1:0] dec_rate,
  output adcr_pkg::adcr_ana_s ana_ctrl,
  output logic filter_restart,
  output logic filter_settled_flag,
  output logic [15:0] gain_value,
  output logic [15:0] threshold_value
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] control;
  adcr_pkg::adcr_sel_e read_sel;
  logic [23:0] data_hold;
  logic [1:0] start_cnt;
  logic [31:0] settle_cnt;
  logic sync_q;
  logic busy;
  logic ack;
  logic [3:0] idx;
  logic hit;
  logic wr_take;
  logic rd_take;
  logic align_req;
  logic [15:0] status_word;
  logic [15:0] wdata;
  logic [15:0] next_control;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // One wait cycle per access keeps readdata registered: the answer is
  // at the second edge of the request.
  assign idx = avs_address[5:2];
  assign hit = (avs_address[1:0] == 2'h0) &&
               (idx == adcr_pkg::IDX_CONTROL || idx == adcr_pkg::IDX_STATUS ||
                idx == adcr_pkg::IDX_GAIN || idx == adcr_pkg::IDX_THRESH ||
                idx == adcr_pkg::IDX_DATA || idx == adcr_pkg::IDX_PINS);
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_take = avs_write && ack && hit;
  assign rd_take = avs_read && ack && hit;
  assign wdata = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                  avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

  // Start-up gap and busy: nothing is accepted for two cycles after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_cnt <= 2'h0;
    end else if (start_cnt != 2'(adcr_pkg::START_GAP_CYC)) begin
      start_cnt <= start_cnt + 2'h1;
    end
  end
  assign busy = (start_cnt != 2'(adcr_pkg::START_GAP_CYC));

  // Acknowledge pulse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack && !busy;
    end
  end

  // Unmapped addresses answer with a slave error
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_response <= 2'h0;
    end else if ((avs_read || avs_write) && !ack) begin
      avs_response <= hit ? 2'h0 : 2'h2;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Select and align bits are stored only for one cycle, then self-clear.
  always_comb begin
    next_control = control & ~adcr_pkg::SELF_CLEAR_MASK;
    if (wr_take && idx == adcr_pkg::IDX_CONTROL) begin
      next_control = wdata & adcr_pkg::CONTROL_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      control <= adcr_pkg::CONTROL_RST;
    end else begin
      control <= next_control;
    end
  end

  // Analog and power controls; power-down keeps all register state
  assign ana_ctrl.power_down = control[adcr_pkg::B_PDOWN];
  assign ana_ctrl.low_power_setting = control[adcr_pkg::B_LOW_POWER_SETTING];
  assign ana_ctrl.ref_buf_off = control[adcr_pkg::B_REFOFF];
  assign ana_ctrl.amplifier_disable = control[adcr_pkg::B_AMPOFF];
  assign ana_ctrl.ref_bypass = control[adcr_pkg::B_BYPASS] & control[adcr_pkg::B_REFOFF];

  // ----------------------------------------
  // Read select, consumed by one data read
  // ----------------------------------------
  // Priority threshold > gain > status if the host breaks the one-bit rule.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      read_sel <= adcr_pkg::ADCR_SEL_DATA;
    end else if (wr_take && idx == adcr_pkg::IDX_CONTROL) begin
      if (wdata[adcr_pkg::B_RD_THR]) begin
        read_sel <= adcr_pkg::ADCR_SEL_THRESH;
      end else if (wdata[adcr_pkg::B_RD_GAIN]) begin
        read_sel <= adcr_pkg::ADCR_SEL_GAIN;
      end else if (wdata[adcr_pkg::B_RD_STAT]) begin
        read_sel <= adcr_pkg::ADCR_SEL_STATUS;
      end
    end else if (rd_take && idx == adcr_pkg::IDX_DATA) begin
      read_sel <= adcr_pkg::ADCR_SEL_DATA;
    end
  end

  // ----------------------------------------
  // Gain and threshold registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gain_value <= adcr_pkg::GAIN_RST;
    end else if (wr_take && idx == adcr_pkg::IDX_GAIN) begin
      gain_value <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      threshold_value <= adcr_pkg::THRESH_RST;
    end else if (wr_take && idx == adcr_pkg::IDX_THRESH) begin
      threshold_value <= wdata;
    end
  end

  // ----------------------------------------
  // Filter alignment and settling
  // ----------------------------------------
  // Rising edge of sync_n ends a pulse; align bit does the same from software.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_q <= 1'b1;
    end else begin
      sync_q <= sync_n;
    end
  end
  assign align_req = (sync_n && !sync_q) || control[adcr_pkg::B_ALIGN];
  assign filter_restart = align_req;

  // Settled flag rises once the count elapses; restart clears it again
  always_ff @(posedge clk_sys) begin
    if (rst || align_req) begin
      settle_cnt <= 32'h0;
      filter_settled_flag <= 1'b0;
    end else if (!ana_ctrl.power_down && !filter_settled_flag) begin
      if (settle_cnt == 32'(SETTLE_CYC - 1)) begin
        filter_settled_flag <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 32'h1;
      end
    end
  end

  // Latest conversion result
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_hold <= 24'h0;
    end else if (conv_valid) begin
      data_hold <= conv_data;
    end
  end

  // ----------------------------------------
  // Status word and read data
  // ----------------------------------------
  always_comb begin
    status_word = adcr_pkg::STATUS_FIXED;
    status_word[adcr_pkg::S_SETTLED] = filter_settled_flag;
    status_word[adcr_pkg::S_OVR] = overrange;
    status_word[adcr_pkg::S_REFON] = !ana_ctrl.ref_buf_off;
    status_word[adcr_pkg::S_AMPON] = !ana_ctrl.amplifier_disable;
    status_word[adcr_pkg::S_LOW_POWER_SETTING] = ana_ctrl.low_power_setting;
    status_word[1:0] = dec_rate;
  end

  // Data word: result plus settled flag in bit 31 so software can discard it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack && !hit) begin
      avs_readdata <= 32'h0; // Misaligned or unmapped: never leak a register
    end else if (avs_read && !ack) begin
      case (idx)
        adcr_pkg::IDX_CONTROL: avs_readdata <= {16'h0, control};
        adcr_pkg::IDX_STATUS: avs_readdata <= {16'h0, status_word};
        adcr_pkg::IDX_GAIN: avs_readdata <= {16'h0, gain_value};
        adcr_pkg::IDX_THRESH: avs_readdata <= {16'h0, threshold_value};
        adcr_pkg::IDX_PINS: avs_readdata <= {31'h0, sync_n};
        adcr_pkg::IDX_DATA: begin
          case (read_sel)
            adcr_pkg::ADCR_SEL_THRESH: avs_readdata <= {16'h0, threshold_value};
            adcr_pkg::ADCR_SEL_GAIN: avs_readdata <= {16'h0, gain_value};
            adcr_pkg::ADCR_SEL_STATUS: avs_readdata <= {16'h0, status_word};
            default: avs_readdata <= {filter_settled_flag, 7'h0, data_hold};
          endcase
        end
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

endmodule

/* File: rtl/adcr_pkg.sv */
// Package for the converter start-up and control register bank.
// Assumes a 16-bit register map reached over a 32-bit Avalon-MM slave.
package adcr_pkg;

  // ----------------------------------------
  // Register word indices and address width
  // ----------------------------------------
  localparam logic [3:0] IDX_CONTROL = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_GAIN = 4'h4;
  localparam logic [3:0] IDX_THRESH = 4'h5;
  localparam logic [3:0] IDX_DATA = 4'h6;
  localparam logic [3:0] IDX_PINS = 4'h7;
  localparam int ADDR_W = 6;

  // ----------------------------------------
  // Reset values and control masks
  // ----------------------------------------
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'hA000;
  localparam logic [15:0] THRESH_RST = 16'hCCCC;
  localparam logic [15:0] CONTROL_MASK = 16'h6A8F;
  localparam logic [15:0] SELF_CLEAR_MASK = 16'h7A00;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int B_RD_THR = 14;
  localparam int B_RD_GAIN = 13;
  localparam int B_RD_STAT = 11;
  localparam int B_ALIGN = 9;
  localparam int B_BYPASS = 7;
  localparam int B_PDOWN = 3;
  localparam int B_LOW_POWER_SETTING = 2;
  localparam int B_REFOFF = 1;
  localparam int B_AMPOFF = 0;

  // ----------------------------------------
  // Status field positions and fixed bits
  // ----------------------------------------
  localparam int S_SETTLED = 10;
  localparam int S_OVR = 8;
  localparam int S_REFON = 4;
  localparam int S_AMPON = 3;
  localparam int S_LOW_POWER_SETTING = 2;
  localparam logic [15:0] STATUS_FIXED = 16'hC040;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int START_GAP_CYC = 2;
  localparam int SETTLE_CYC_DEF = 4096;

  typedef enum logic [1:0] {
    ADCR_SEL_DATA,
    ADCR_SEL_THRESH,
    ADCR_SEL_GAIN,
    ADCR_SEL_STATUS
  } adcr_sel_e;

  typedef struct packed {
    logic power_down;
    logic low_power_setting;
    logic ref_buf_off;
    logic amplifier_disable;
    logic ref_bypass;
  } adcr_ana_s;

endpackage

/* File: testbench/adcr_regs_asserts.sv */
// Checker for the converter control register bank: bus answers, reset, settling.
// Assumes it is bound to adcr_regs with the same SETTLE_CYC.
module adcr_regs_asserts #(
  parameter int SETTLE_CYC = adcr_pkg::SETTLE_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [adcr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic sync_n,
  input wire adcr_pkg::adcr_ana_s ana_ctrl,
  input wire logic filter_restart,
  input wire logic filter_settled_flag,
  input wire logic [15:0] gain_value
);
  logic rd_done;
  logic wr_ctl;
  logic bad_adr;
  logic [15:0] quiet;
  assign rd_done = avs_read & !avs_waitrequest;
  assign bad_adr = avs_address[1:0] != 2'h0 || !(avs_address[5:2] inside {adcr_pkg::IDX_CONTROL, adcr_pkg::IDX_STATUS,
    adcr_pkg::IDX_GAIN, adcr_pkg::IDX_THRESH, adcr_pkg::IDX_DATA, adcr_pkg::IDX_PINS});
  assign wr_ctl = avs_write & !avs_waitrequest & !bad_adr & (avs_address[5:2] == 4'h1);
  // Settle count stalls in power-down, as the datapath does
  always_ff @(posedge clk_sys) begin
    if (rst || filter_restart) quiet <= 16'h0000;
    else if (!ana_ctrl.power_down && quiet != 16'hFFFF) quiet <= quiet + 16'h0001;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_answer; (avs_read || avs_write) |-> ##[0:4] !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("bus request left waiting");
  property p_rst; disable iff (1'b0) rst |=> ana_ctrl == '0 && !filter_settled_flag && gain_value == 16'hA000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_unmap; rd_done && bad_adr |-> avs_response == 2'h2 && avs_readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_ctl_rd; rd_done && !bad_adr && avs_address[5:2] == 4'h1 |-> (avs_readdata & ~32'h6A8F) == 32'h0;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control undefined bit set");
  property p_ana; wr_ctl && avs_byteenable[0] |=> ana_ctrl.power_down == $past(avs_writedata[3])
    && ana_ctrl.ref_buf_off == $past(avs_writedata[1]) && ana_ctrl.amplifier_disable == $past(avs_writedata[0])
    && ana_ctrl.low_power_setting == $past(avs_writedata[2])
    && ana_ctrl.ref_bypass == ($past(avs_writedata[7]) && $past(avs_writedata[1]));
  endproperty
  a_ana: assert property (p_ana) else $error("analog controls not following control");
  property p_gain; avs_write && !avs_waitrequest && avs_address == 6'h10 && avs_byteenable[1:0] == 2'h3
    |=> gain_value == $past(avs_writedata[15:0]); endproperty
  a_gain: assert property (p_gain) else $error("gain write lost");
  property p_sync; $rose(sync_n) |-> filter_restart; endproperty
  a_sync: assert property (p_sync) else $error("align pulse ignored");
  property p_align; wr_ctl && avs_writedata[9] && avs_byteenable[1] |-> ##[0:2] filter_restart; endproperty
  a_align: assert property (p_align) else $error("align bit ignored");
  property p_clr; filter_restart |=> !filter_settled_flag; endproperty
  a_clr: assert property (p_clr) else $error("settled kept over restart");
  property p_settle; quiet == SETTLE_CYC |-> filter_settled_flag; endproperty
  a_settle: assert property (p_settle) else $error("settled flag late");
  property p_early; quiet == SETTLE_CYC - 1 |-> !filter_settled_flag; endproperty
  a_early: assert property (p_early) else $error("settled flag early");
  c_sync: cover property ($rose(sync_n));
  c_settle: cover property ($rose(filter_settled_flag));
  c_unmap: cover property (rd_done && bad_adr);
  c_sel: cover property (rd_done && avs_address == 6'h18);
endmodule
bind adcr_regs adcr_regs_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_adcr_regs_asserts (.clk_sys(clk_sys), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .sync_n(sync_n), .ana_ctrl(ana_ctrl), .filter_restart(filter_restart),
  .filter_settled_flag(filter_settled_flag), .gain_value(gain_value));

/* File: testbench/adcr_host_model.sv */
// Host-side model of the align pin: idle high, a low pulse on request.
// Assumes go is a one-cycle request and busy marks a bus write in flight.
module adcr_host_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic busy,
  output logic sync_n
);
  logic [2:0] low_left;
  // Refused while a write runs so the two never overlap; five low cycles give margin
  always_ff @(posedge clk_sys) begin
    if (rst) low_left <= 3'h0;
    else if (go && !busy && low_left == 3'h0) low_left <= 3'h5;
    else if (low_left != 3'h0) low_left <= low_left - 3'h1;
  end
  assign sync_n = (low_left == 3'h0);
endmodule

/* File: testbench/adc_startup_and_control_regs_tb.sv */
// Self-checking bench for the converter control register bank.
// Assumes the checker is bound from its own file and SETTLE_CYC is shortened.
module adc_startup_and_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 16;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [adcr_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic sync_n;
  logic [23:0] conv_data = '0;
  logic conv_valid = 1'b0;
  logic overrange = 1'b0;
  logic [1:0] dec_rate = 2'h0;
  adcr_pkg::adcr_ana_s ana_ctrl;
  logic filter_restart;
  logic filter_settled_flag;
  logic [15:0] gain_value;
  logic [15:0] threshold_value;
  logic go = 1'b0;
  logic [33:0] notes[$];
  int bad_count = 0;
  int comparisons = 0;
  int seed = 32'h7e51;
  logic [15:0] g;
  logic [15:0] t;
  logic [15:0] sts;
  always #20 clk_sys = ~clk_sys;
  adcr_regs #(.SETTLE_CYC(SETTLE)) u_adcr_regs (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .sync_n(sync_n), .conv_data(conv_data), .conv_valid(conv_valid), .overrange(overrange),
    .dec_rate(dec_rate), .ana_ctrl(ana_ctrl), .filter_restart(filter_restart),
    .filter_settled_flag(filter_settled_flag), .gain_value(gain_value), .threshold_value(threshold_value));
  adcr_host_model u_adcr_host_model (.clk_sys(clk_sys), .rst(rst), .go(go), .busy(avs_write), .sync_n(sync_n));
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One bus cycle; the request is held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [33:0] e);
    int n;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= !w;
    if (!w) notes.push_back(e);
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 40) bad_count++;
    if (n == 40) final_report();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Read results are taken at the same edge that sees waitrequest low
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk("read", notes.pop_front(), {avs_response, avs_readdata});
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end
  initial begin
    @(posedge clk_sys);
    conv_data <= 24'($random(seed));
    conv_valid <= 1'b1;
    overrange <= 1'($random(seed));
    dec_rate <= 2'($random(seed));
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    acc(1'b0, 6'h04, 16'h0, 34'h0);
    acc(1'b0, 6'h14, 16'h0, {18'h0, 16'hCCCC});
    acc(1'b0, 6'h1C, 16'h0, 34'h1);
    g = 16'($random(seed));
    t = 16'($random(seed));
    acc(1'b1, 6'h10, g, 34'h0);
    acc(1'b0, 6'h10, 16'h0, {18'h0, g});
    chk("gain", {18'h0, g}, {18'h0, gain_value});
    acc(1'b1, 6'h14, t, 34'h0);
    acc(1'b0, 6'h14, 16'h0, {18'h0, t});
    chk("threshold", {18'h0, t}, {18'h0, threshold_value});
    repeat (SETTLE + 8) @(posedge clk_sys);
    sts = 16'hC458 | {7'h0, overrange, 6'h0, dec_rate};
    acc(1'b0, 6'h08, 16'h0, {18'h0, sts});
    // Each select redirects exactly one data read, then data returns
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 6'h04, (i == 0) ? 16'h4000 : (i == 1) ? 16'h2000 : 16'h0800, 34'h0);
      acc(1'b0, 6'h18, 16'h0, {18'h0, (i == 0) ? t : (i == 1) ? g : sts});
      acc(1'b0, 6'h18, 16'h0, {2'h0, 1'b1, 7'h0, conv_data});
    end
    acc(1'b0, 6'h00, 16'h0, {2'h2, 32'h0});
    // All fields and undefined bits set, but only one read-select bit, as the host must
    acc(1'b1, 6'h04, 16'hD7FF, 34'h0);
    acc(1'b0, 6'h04, 16'h0, {18'h0, 16'h008F});
    chk("ana_ctrl", 34'h1F, {29'h0, ana_ctrl});
    acc(1'b0, 6'h05, 16'h0, {2'h2, 32'h0});
    acc(1'b0, 6'h18, 16'h0, {18'h0, t});
    acc(1'b0, 6'h18, 16'h0, {2'h0, 1'b0, 7'h0, conv_data});
    acc(1'b1, 6'h04, 16'h0, 34'h0);
    chk("ana_ctrl", 34'h0, {29'h0, ana_ctrl});
    repeat (SETTLE + 8) @(posedge clk_sys);
    chk("settled", 34'h1, {33'h0, filter_settled_flag});
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("settled", 34'h0, {33'h0, filter_settled_flag});
    repeat (SETTLE + 8) @(posedge clk_sys);
    chk("settled", 34'h1, {33'h0, filter_settled_flag});
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("settled", 34'h0, {33'h0, filter_settled_flag});
    acc(1'b0, 6'h10, 16'h0, {18'h0, 16'hA000});
    acc(1'b0, 6'h14, 16'h0, {18'h0, 16'hCCCC});
    final_report();
  end
endmodule
